// File: inc/ssp_cfg.svh
// Purpose: Constants of the safe-state passivation controller.
// Assumes: One 250 MHz clock; APB register access with 32-bit data.
// Notes:   Offsets are byte addresses; every timing count derives from these times.
//
// Summary of operation
// - Logic zero, de-energized, is the only safe value of every channel.
// - After startup all channels stay passivated until normal operation begins.
// - A module-wide fault passivates every channel of the module.
// - A channel diagnostic fault passivates only that channel and, when paired, its partner.
// - A safety message timeout or communication error passivates all channels.
// - A passivated input reports zero instead of its sensed value.
// - A passivated output drives zero regardless of the commanded value.
// - Outputs are zero while stopped; no energized default exists.
// - No fault memory survives a power cycle; faults are detected anew.
// - Single inputs passivate alone; paired inputs passivate together.
// - Solid-state outputs check high and low switches; either failure passivates.
// - Relay outputs check both relays; either failure passivates the channel.
// - Reintegration is automatic or manual per channel or per module.
// - Communication passivation always needs a manual acknowledge.
// - Automatic channels reintegrate at once when their fault clears.
// - Request flag is high while a manual channel is ready to reintegrate.
// - Acknowledge is honoured only while the request flag is high.
// - The group-wide acknowledge input acts like the module acknowledge.
// - Fatal faults refuse acknowledge; only power cycle recovers.
// - On reintegration inputs report sensed values, outputs follow commands.
// - Channel passivation lasting 100 hours passivates the module until power cycle.
// - Deactivated channels get no diagnostics and raise no faults.
// - Channel acknowledge mode defaults to manual.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Channel counts.
`define SSP_NDI 8
`define SSP_NDQ 4
`define SSP_NCH 12
`define SSP_NPR 4
`define SSP_PIN_W 29

// Register byte offsets.
`define SSP_CTRL_OFS 8'h00
`define SSP_EN_OFS 8'h04
`define SSP_AUTO_OFS 8'h08
`define SSP_PAIR_OFS 8'h0C
`define SSP_CMD_OFS 8'h10
`define SSP_STAT_OFS 8'h14
`define SSP_PASV_OFS 8'h18
`define SSP_DI_OFS 8'h1C

// Control register fields.
`define SSP_CTRL_RUN 0
`define SSP_CTRL_ACK 1
`define SSP_CTRL_MAUTO 2

// Reset values.
`define SSP_EN_RST 12'hFFF
`define SSP_AUTO_RST 12'h000
`define SSP_PAIR_RST 4'h0

// Timing.
`define SSP_CLK_NS 4
`define SSP_TICK_NS 1000000
`define SSP_HOLD_H 100
`define SSP_MS_PER_H 3600000
`define SSP_DIV_W 18
`define SSP_HOLD_W 29

`endif

// File: inc/ssp_pkg.sv
// Purpose: Types of the safe-state passivation controller.
// Assumes: ssp_cfg.svh holds the widths.
// Notes:   All state of each module is one packed struct.
`include "ssp_cfg.svh"
`default_nettype none
package ssp_pkg;

  // Operating mode; start and run differ in one bit, run and stop in one.
  typedef enum logic [1:0] {
    SSP_START = 2'h0,
    SSP_RUN = 2'h1,
    SSP_STOP = 2'h3
  } ssp_mode_e;

  // Controller state.
  typedef struct packed {
    logic [`SSP_PIN_W-1:0] s1;
    logic [`SSP_PIN_W-1:0] s2;
    logic gack_d;
    ssp_mode_e st;
    logic run;
    logic mauto;
    logic [`SSP_NCH-1:0] en;
    logic [`SSP_NCH-1:0] auto;
    logic [`SSP_NPR-1:0] pair;
    logic [`SSP_NDQ-1:0] cmd;
    logic [`SSP_NCH-1:0] pas;
    logic mod_pas;
    logic comm_lat;
    logic fatal_lat;
    logic life_lat;
    logic [`SSP_DIV_W-1:0] div;
    logic [`SSP_NDI-1:0] di_rep;
    logic [`SSP_NDQ-1:0] dq;
    logic [31:0] prdata;
  } ssp_state_s;

  // Persistence timer state.
  typedef struct packed {
    logic [`SSP_HOLD_W-1:0] cnt;
    logic done;
  } ssp_tmr_s;

endpackage : ssp_pkg
`default_nettype wire

// File: src/ssp_persist_timer.sv
// Purpose: Measures how long one channel stays passivated.
// Assumes: tick is a one-cycle enable from the millisecond divider.
// Notes:   expired stays high until the channel leaves passivation.
`include "ssp_cfg.svh"
`default_nettype none
module ssp_persist_timer #(
  parameter int unsigned HOLD_TICKS = `SSP_HOLD_H * `SSP_MS_PER_H
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Time base and channel state.
  input wire logic tick,
  input wire logic active,
  // Result.
  output logic expired
);

  ssp_pkg::ssp_tmr_s t_r;
  ssp_pkg::ssp_tmr_s t_nxt;

  // Count ticks while passivated; any gap restarts from zero.
  always_comb begin
    t_nxt = t_r;
    if (!active) begin
      t_nxt.cnt = '0;
      t_nxt.done = 1'b0;
    end else if (tick && !t_r.done) begin
      t_nxt.cnt = t_r.cnt + `SSP_HOLD_W'(1);
      if (t_r.cnt == `SSP_HOLD_W'(HOLD_TICKS - 1)) begin
        t_nxt.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign expired = t_r.done;

endmodule : ssp_persist_timer
`default_nettype wire

// File: src/ssp_ctrl.sv
// Purpose: Passivation and reintegration controller of a fail-safe I/O module.
// Assumes: Diagnostic results arrive as fault pins; all pins but the APB bus are asynchronous.
// Notes:   Channels 0..7 are inputs, 8..11 are outputs in the channel vectors.
`include "ssp_cfg.svh"
`default_nettype none
module ssp_ctrl #(
  parameter int unsigned TICK_CYCLES = `SSP_TICK_NS / `SSP_CLK_NS,
  parameter int unsigned HOLD_TICKS = `SSP_HOLD_H * `SSP_MS_PER_H
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensed inputs and their diagnostics.
  input wire logic [`SSP_NDI-1:0] di_raw,
  input wire logic [`SSP_NDI-1:0] di_fault,
  // Output switch or relay diagnostics, first and second element.
  input wire logic [`SSP_NDQ-1:0] dq_fault_a,
  input wire logic [`SSP_NDQ-1:0] dq_fault_b,
  // Module and communication faults; group-wide acknowledge.
  input wire logic module_fault,
  input wire logic fatal_fault,
  input wire logic comm_timeout,
  input wire logic comm_error,
  input wire logic group_wide_ack_input,
  // Process side.
  output logic [`SSP_NDI-1:0] di_report,
  output logic [`SSP_NDQ-1:0] dq_out,
  // Status.
  output logic ack_req,
  output logic module_passivated
);

  // ****************************************************************
  // State and synchronised pins
  // ****************************************************************

  ssp_pkg::ssp_state_s s_r;
  ssp_pkg::ssp_state_s s_nxt;

  logic [`SSP_NDI-1:0] di_v;
  logic [`SSP_NDI-1:0] di_f;
  logic [`SSP_NDQ-1:0] fa;
  logic [`SSP_NDQ-1:0] fb;
  logic modf;
  logic fatal;
  logic comm;
  logic g_ack;

  // Only the second flip-flop of each synchroniser is read.
  assign di_v = s_r.s2[7:0];
  assign di_f = s_r.s2[15:8];
  assign fa = s_r.s2[19:16];
  assign fb = s_r.s2[23:20];
  assign modf = s_r.s2[24];
  assign fatal = s_r.s2[25];
  assign comm = s_r.s2[26] | s_r.s2[27];
  assign g_ack = s_r.s2[28];

  // ****************************************************************
  // Channel fault evaluation
  // ****************************************************************

  logic [`SSP_NDI-1:0] di_m;
  logic [`SSP_NDI-1:0] di_swp;
  logic [`SSP_NDI-1:0] pair_m;
  logic [`SSP_NCH-1:0] flt;

  // Deactivated channels are masked before anything sees their faults.
  assign di_m = di_f & s_r.en[7:0];
  assign di_swp = {di_m[6], di_m[7], di_m[4], di_m[5], di_m[2], di_m[3], di_m[0], di_m[1]};
  assign pair_m = {{2{s_r.pair[3]}}, {2{s_r.pair[2]}}, {2{s_r.pair[1]}}, {2{s_r.pair[0]}}};
  // A paired input also takes its partner's fault; a lone one only its own.
  assign flt[7:0] = di_m | (di_swp & pair_m);
  // Either switch or either relay failing passivates the output channel.
  assign flt[11:8] = (fa | fb) & s_r.en[11:8];

  // ****************************************************************
  // Reintegration handshake
  // ****************************************************************

  logic [`SSP_NCH-1:0] rdy;
  logic mod_clear;
  logic mod_rdy;
  logic wr;
  logic ack_w;
  logic g_edge;
  logic ack;

  // A manual channel whose fault has gone waits for acknowledge.
  assign rdy = s_r.pas & ~flt & ~s_r.auto;
  // Fatal and long-passivation latches keep the module from ever clearing.
  assign mod_clear = ~modf & ~comm & ~s_r.fatal_lat & ~s_r.life_lat;
  // Communication passivation needs acknowledge even in automatic mode.
  assign mod_rdy = s_r.mod_pas & mod_clear & (s_r.comm_lat | ~s_r.mauto);
  assign ack_req = (|rdy) | mod_rdy;
  assign wr = psel & penable & pwrite;
  assign ack_w = wr & (paddr == `SSP_CTRL_OFS) & pwdata[`SSP_CTRL_ACK];
  assign g_edge = g_ack & ~s_r.gack_d;
  // Acknowledge outside a pending request is ignored.
  assign ack = (ack_w | g_edge) & ack_req;

  // ****************************************************************
  // Passivation summary and time base
  // ****************************************************************

  logic [`SSP_NCH-1:0] eff;
  logic [`SSP_NCH-1:0] expire;
  logic tick;
  logic mod_set;

  // Startup and module passivation cover every channel.
  assign eff = s_r.pas | {`SSP_NCH{s_r.mod_pas | (s_r.st == ssp_pkg::SSP_START)}};
  assign tick = (s_r.div == `SSP_DIV_W'(TICK_CYCLES - 1));
  assign mod_set = modf | comm | fatal | s_r.fatal_lat | s_r.life_lat | (|expire);
  assign module_passivated = s_r.mod_pas;

  // One timer per channel; any expiry escalates to the whole module.
  for (genvar i = 0; i < `SSP_NCH; i++) begin : g_tmr
    ssp_persist_timer #(
      .HOLD_TICKS(HOLD_TICKS)
    ) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .active(s_r.pas[i]),
      .expired(expire[i])
    );
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Bus, handshake, passivation and output values in one place.
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = {group_wide_ack_input, comm_error, comm_timeout, fatal_fault, module_fault,
                dq_fault_b, dq_fault_a, di_fault, di_raw};
    s_nxt.s2 = s_r.s1;
    s_nxt.gack_d = g_ack;
    s_nxt.div = tick ? '0 : s_r.div + `SSP_DIV_W'(1);

    // Software register writes.
    if (wr) begin
      unique case (paddr)
        `SSP_CTRL_OFS: begin
          s_nxt.run = pwdata[`SSP_CTRL_RUN];
          s_nxt.mauto = pwdata[`SSP_CTRL_MAUTO];
        end
        `SSP_EN_OFS: s_nxt.en = pwdata[`SSP_NCH-1:0];
        `SSP_AUTO_OFS: s_nxt.auto = pwdata[`SSP_NCH-1:0];
        `SSP_PAIR_OFS: s_nxt.pair = pwdata[`SSP_NPR-1:0];
        `SSP_CMD_OFS: s_nxt.cmd = pwdata[`SSP_NDQ-1:0];
        default: s_nxt.cmd = s_r.cmd;
      endcase
    end

    // Read data is captured in the setup phase and stands through access.
    if (psel && !penable) begin
      unique case (paddr)
        `SSP_CTRL_OFS: s_nxt.prdata = {29'h0, s_r.mauto, 1'b0, s_r.run};
        `SSP_EN_OFS: s_nxt.prdata = {20'h0, s_r.en};
        `SSP_AUTO_OFS: s_nxt.prdata = {20'h0, s_r.auto};
        `SSP_PAIR_OFS: s_nxt.prdata = {28'h0, s_r.pair};
        `SSP_CMD_OFS: s_nxt.prdata = {28'h0, s_r.cmd};
        `SSP_STAT_OFS: s_nxt.prdata = {25'h0, s_r.life_lat, s_r.fatal_lat, s_r.comm_lat,
                                       s_r.mod_pas, ack_req, s_r.st};
        `SSP_PASV_OFS: s_nxt.prdata = {20'h0, eff};
        `SSP_DI_OFS: s_nxt.prdata = {24'h0, s_r.di_rep};
        default: s_nxt.prdata = 32'h0;
      endcase
    end

    // Operating mode; nothing runs before software declares operation.
    unique case (s_r.st)
      ssp_pkg::SSP_START: if (s_r.run) s_nxt.st = ssp_pkg::SSP_RUN;
      ssp_pkg::SSP_RUN: if (!s_r.run) s_nxt.st = ssp_pkg::SSP_STOP;
      ssp_pkg::SSP_STOP: if (s_r.run) s_nxt.st = ssp_pkg::SSP_RUN;
      default: s_nxt.st = ssp_pkg::SSP_START;
    endcase

    // Channel passivation: a present fault always wins over a release.
    s_nxt.pas = ((s_r.pas & ~(s_r.auto & ~flt) & ~({`SSP_NCH{ack}} & rdy)) | flt)
                & s_r.en;

    // Module latches; a new event in the acknowledge cycle is kept.
    s_nxt.comm_lat = (s_r.comm_lat & ~(ack & mod_rdy)) | comm;
    s_nxt.fatal_lat = s_r.fatal_lat | fatal;
    s_nxt.life_lat = s_r.life_lat | (|expire);
    s_nxt.mod_pas = mod_set | (s_r.mod_pas & ~(mod_clear & ((s_r.mauto & ~s_r.comm_lat)
                    | (ack & mod_rdy))));

    // Safe value is zero; outputs also need the running mode.
    s_nxt.di_rep = di_v & ~eff[7:0];
    s_nxt.dq = s_r.cmd & ~eff[11:8] & {`SSP_NDQ{s_r.st == ssp_pkg::SSP_RUN}};
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset clears every fault memory, so faults must be seen again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.en <= `SSP_EN_RST;
      s_r.auto <= `SSP_AUTO_RST;
      s_r.pair <= `SSP_PAIR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > `SSP_DI_OFS | paddr[1:0] != 2'b00);
  assign prdata = s_r.prdata;
  assign di_report = s_r.di_rep;
  assign dq_out = s_r.dq;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start;
    (s_r.st == ssp_pkg::SSP_START) |=> (dq_out == '0) && (di_report == '0);
  endproperty
  a_start: assert property (p_start) else $error("Startup left a channel live.");

  property p_modf;
    modf |=> s_r.mod_pas ##1 (dq_out == '0);
  endproperty
  a_modf: assert property (p_modf) else $error("Module fault did not passivate.");

  property p_chan;
    flt[0] |=> s_r.pas[0] ##1 !di_report[0];
  endproperty
  a_chan: assert property (p_chan) else $error("Input fault did not reach zero.");

  property p_comm;
    comm |=> s_r.comm_lat && s_r.mod_pas;
  endproperty
  a_comm: assert property (p_comm) else $error("Communication fault not latched.");

  property p_dq;
    eff[8] |=> !dq_out[0];
  endproperty
  a_dq: assert property (p_dq) else $error("Passivated output energized.");

  property p_stop;
    !s_r.run ##1 !s_r.run |=> (dq_out == '0);
  endproperty
  a_stop: assert property (p_stop) else $error("Output energized while stopped.");

  property p_pair;
    s_r.pair[1] && di_m[2] && s_r.en[3] |=> s_r.pas[2] && s_r.pas[3];
  endproperty
  a_pair: assert property (p_pair) else $error("Pair not passivated together.");

  property p_auto;
    s_r.pas[0] && s_r.auto[0] && !flt[0] |=> !s_r.pas[0];
  endproperty
  a_auto: assert property (p_auto) else $error("Automatic channel not released.");

  property p_noack;
    !ack_req && s_r.pas[0] && !s_r.auto[0] |=> s_r.pas[0] || !s_r.en[0];
  endproperty
  a_noack: assert property (p_noack) else $error("Channel released without request.");

  property p_fatal;
    s_r.fatal_lat |=> s_r.fatal_lat && s_r.mod_pas && !mod_rdy;
  endproperty
  a_fatal: assert property (p_fatal) else $error("Fatal fault was released.");

  property p_life;
    |expire |=> s_r.life_lat && s_r.mod_pas;
  endproperty
  a_life: assert property (p_life) else $error("Long passivation not escalated.");

  property p_dead;
    !s_r.en[0] |=> !s_r.pas[0];
  endproperty
  a_dead: assert property (p_dead) else $error("Deactivated channel passivated.");

endmodule : ssp_ctrl
`default_nettype wire

// File: test/ssp_cpu_model.sv
// Purpose: Safety program side of the passivation controller.
// Assumes: The bench tells the model when to acknowledge or drop messages.
// Notes:   Acknowledges only while the device raises its request flag.
`include "ssp_cfg.svh"
`default_nettype none
module ssp_cpu_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench.
  input wire logic want_gack,
  input wire logic miss_msg,
  // Device status and program lines.
  input wire logic ack_req,
  output logic group_wide_ack_input,
  output logic comm_timeout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_r;
  // The pulse lasts three cycles so the device synchroniser cannot miss it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      group_wide_ack_input <= 1'b0;
      comm_timeout <= 1'b0;
    end else begin
      comm_timeout <= miss_msg;
      if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end else if (want_gack && ack_req) begin
        cnt_r <= 2'h3;
      end
      group_wide_ack_input <= (cnt_r != 2'h0);
    end
  end
endmodule : ssp_cpu_model
`default_nettype wire

// File: test/test_safe_state_passivation_ctrl.sv
// Purpose: Self-checking bench of the passivation controller.
// Assumes: Short tick and hold counts keep the persistence test brief.
// Notes:   Pins need about four edges to reach the outputs.
`include "ssp_cfg.svh"
`default_nettype none
module test_safe_state_passivation_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ack_req, mod_pas, gack, comm_to, er;
  logic [7:0] di_raw = 8'hA5, di_fault = 8'h00, di_report;
  logic [3:0] dq_a = 4'h0, dq_b = 4'h0, dq_out;
  logic module_fault = 1'b0, fatal_fault = 1'b0, want_gack = 1'b0, miss_msg = 1'b0;
  logic comm_err = 1'b0;
  int err_count = 0;
  int checks = 0;
  // A half period of 2 ns gives 250 MHz.
  always #2 pclk = ~pclk;
  ssp_ctrl #(.TICK_CYCLES(4), .HOLD_TICKS(16)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .di_raw(di_raw),
    .di_fault(di_fault), .dq_fault_a(dq_a), .dq_fault_b(dq_b),
    .module_fault(module_fault), .fatal_fault(fatal_fault), .comm_timeout(comm_to),
    .comm_error(comm_err), .group_wide_ack_input(gack), .di_report(di_report),
    .dq_out(dq_out), .ack_req(ack_req), .module_passivated(mod_pas));
  ssp_cpu_model cpu (.pclk(pclk), .presetn(presetn), .want_gack(want_gack),
    .miss_msg(miss_msg), .ack_req(ack_req), .group_wide_ack_input(gack),
    .comm_timeout(comm_to));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Sampling 1 ns after the edge lets that edge's updates land first.
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic give_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_start;
    wt(2);
    chk(di_report, 32'h0);
    chk(dq_out, 32'h0);
    rdc(`SSP_EN_OFS, 32'hFFF);
    rdc(`SSP_AUTO_OFS, 32'h0);
    rdc(`SSP_PAIR_OFS, 32'h0);
    rdc(8'h20, 32'h0);
    chk(er, 32'h1);
    wr(`SSP_CMD_OFS, 32'hF);
    wr(`SSP_CTRL_OFS, 32'h1);
    wt(4);
    chk(di_report, 32'hA5);
    chk(dq_out, 32'hF);
    $display("start done");
  endtask : t_start
  task automatic t_chan;
    wr(`SSP_PAIR_OFS, 32'h2);
    @(posedge pclk);
    di_fault <= 8'h05;
    dq_a <= 4'h1;
    dq_b <= 4'h2;
    wt(6);
    chk(di_report, 32'hA0);
    chk(dq_out, 32'hC);
    rdc(`SSP_PASV_OFS, 32'h30D);
    wr(`SSP_CTRL_OFS, 32'h3);
    wt(4);
    chk(di_report, 32'hA0);
    di_fault <= 8'h00;
    dq_a <= 4'h0;
    dq_b <= 4'h0;
    wt(6);
    chk(ack_req, 32'h1);
    chk(dq_out, 32'hC);
    wr(`SSP_CTRL_OFS, 32'h3);
    wt(2);
    chk(ack_req, 32'h0);
    chk(di_report, 32'hA5);
    chk(dq_out, 32'hF);
    wr(`SSP_PAIR_OFS, 32'h0);
    $display("channel done");
  endtask : t_chan
  task automatic t_auto;
    wr(`SSP_AUTO_OFS, 32'h101);
    @(posedge pclk);
    di_fault <= 8'h01;
    dq_a <= 4'h1;
    wt(6);
    chk(di_report, 32'hA4);
    chk(dq_out, 32'hE);
    di_fault <= 8'h00;
    dq_a <= 4'h0;
    wt(6);
    chk(di_report, 32'hA5);
    chk(dq_out, 32'hF);
    chk(ack_req, 32'h0);
    $display("auto done");
  endtask : t_auto
  task automatic t_mod;
    @(posedge pclk);
    module_fault <= 1'b1;
    wt(6);
    chk({mod_pas, di_report, dq_out}, 32'h1000);
    module_fault <= 1'b0;
    wt(6);
    chk(ack_req, 32'h1);
    want_gack <= 1'b1;
    wt(12);
    want_gack <= 1'b0;
    chk({mod_pas, di_report, dq_out}, 32'h0A5F);
    $display("module done");
  endtask : t_mod
  task automatic t_comm;
    wr(`SSP_CTRL_OFS, 32'h5);
    @(posedge pclk);
    miss_msg <= 1'b1;
    wt(6);
    chk({mod_pas, di_report, dq_out}, 32'h1000);
    miss_msg <= 1'b0;
    wt(8);
    chk(mod_pas, 32'h1);
    wr(`SSP_CTRL_OFS, 32'h7);
    wt(2);
    chk(mod_pas, 32'h0);
    module_fault <= 1'b1;
    wt(6);
    module_fault <= 1'b0;
    wt(8);
    chk({mod_pas, dq_out}, 32'h0F);
    comm_err <= 1'b1;
    wt(6);
    chk({mod_pas, dq_out}, 32'h10);
    comm_err <= 1'b0;
    wt(8);
    chk(ack_req, 32'h1);
    wr(`SSP_CTRL_OFS, 32'h7);
    wt(2);
    chk(mod_pas, 32'h0);
    wr(`SSP_CTRL_OFS, 32'h1);
    $display("comm done");
  endtask : t_comm
  task automatic t_misc;
    wr(`SSP_EN_OFS, 32'hFFE);
    @(posedge pclk);
    di_fault <= 8'h01;
    wt(6);
    chk(di_report, 32'hA5);
    rdc(`SSP_PASV_OFS, 32'h0);
    di_fault <= 8'h00;
    wr(`SSP_EN_OFS, 32'hFFF);
    wr(`SSP_CTRL_OFS, 32'h0);
    wt(3);
    chk({di_report, dq_out}, 32'hA50);
    wr(`SSP_CTRL_OFS, 32'h1);
    wt(3);
    chk(dq_out, 32'hF);
    $display("stop done");
  endtask : t_misc
  task automatic t_hold;
    wr(`SSP_AUTO_OFS, 32'h0);
    @(posedge pclk);
    di_fault <= 8'h10;
    wt(100);
    chk({mod_pas, di_report}, 32'h100);
    di_fault <= 8'h00;
    wt(6);
    wr(`SSP_CTRL_OFS, 32'h3);
    wt(3);
    chk(mod_pas, 32'h1);
    apb(1'b0, `SSP_STAT_OFS, 32'h0);
    chk(rd & 32'h68, 32'h48);
    $display("hold done");
  endtask : t_hold
  task automatic t_fatal;
    @(posedge pclk);
    presetn <= 1'b0;
    wt(3);
    presetn <= 1'b1;
    wt(2);
    chk(mod_pas, 32'h0);
    rdc(`SSP_STAT_OFS, 32'h0);
    wr(`SSP_CMD_OFS, 32'hF);
    wr(`SSP_CTRL_OFS, 32'h1);
    @(posedge pclk);
    fatal_fault <= 1'b1;
    wt(4);
    fatal_fault <= 1'b0;
    wt(6);
    wr(`SSP_CTRL_OFS, 32'h3);
    wt(3);
    chk({mod_pas, dq_out}, 32'h10);
    $display("fatal done");
  endtask : t_fatal
  // Main sequence; reset is held for three cycles.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_start;
    t_chan;
    t_auto;
    t_mod;
    t_comm;
    t_misc;
    t_hold;
    t_fatal;
    give_verdict;
  end
  // The tests take about 350 cycles; over twenty times that means a hang.
  initial begin
    #32000;
    err_count++;
    give_verdict;
  end
endmodule : test_safe_state_passivation_ctrl
`default_nettype wire
